// [fbr_pkg.sv]
// Constants, types and helpers shared by the flash bus read-mode logic
package fbr_pkg;

  localparam int CLK_MHZ       = 20;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int GLITCH_NS     = 5;
  localparam int GLITCH_RAW    = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GLITCH_CYC    = (GLITCH_RAW < 1) ? 1 : GLITCH_RAW;

  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;

  localparam logic [2:0] LAT_CODE_MIN = 3'h2;
  localparam logic [2:0] LAT_CODE_MAX = 3'h6;
  localparam logic [3:0] LAT_BIAS     = 4'h2;
  localparam logic [3:0] LAT_SLOWEST  = 4'h8;

  localparam logic [2:0] BL_4      = 3'h1;
  localparam logic [2:0] BL_8      = 3'h2;
  localparam logic [2:0] BL_CONT   = 3'h7;
  localparam logic [2:0] MASK_1    = 3'h0;
  localparam logic [2:0] MASK_4    = 3'h3;
  localparam logic [2:0] MASK_8    = 3'h7;
  localparam logic [1:0] PAGE_FIRST = 2'h0;
  localparam logic [1:0] PAGE_LAST  = 2'h3;

  typedef struct packed {
    logic       read_select_bit;
    logic [2:0] first_access_latency;
    logic       ready_timing_bit;
    logic       burst_order_bit;
    logic       active_edge_bit;
    logic [2:0] burst_length_field;
  } fbr_cfg_t;

  localparam fbr_cfg_t CFG_RESET = '{1'b1, LAT_CODE_MAX, 1'b0, 1'b1, 1'b1, BL_4};

  typedef struct packed {
    logic reset_powerdown_n;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic latch_n;
    logic bus_clk;
  } fbr_ctl_t;

  localparam fbr_ctl_t CTL_IDLE = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

  typedef enum logic [1:0] {B_IDLE, B_LAT, B_DATA} fbr_bst_t;

  function automatic logic [3:0] fbr_lat_cycles(input logic [2:0] code);
    if (code >= LAT_CODE_MIN && code <= LAT_CODE_MAX) return {1'b0, code} + LAT_BIAS;
    return LAT_SLOWEST;
  endfunction

  function automatic logic [ADDR_W-1:0] fbr_burst_addr(input logic [ADDR_W-1:0] base,
                                                      input logic [2:0] idx,
                                                      input logic [2:0] mask,
                                                      input logic seq);
    logic [2:0] low;
    low = seq ? (base[2:0] + idx) : (base[2:0] ^ idx);
    return {base[ADDR_W-1:3], (base[2:0] & ~mask) | (low & mask)};
  endfunction

endpackage

// [fbr_pin_filt.sv]
// Two-stage synchroniser followed by a stability filter for control pins
`timescale 1ns/10ps
module fbr_pin_filt #(
  parameter int               WIDTH    = 6,
  parameter int               FILT_CYC = 1,
  parameter logic [WIDTH-1:0] RST_VAL  = '0
)(
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] pins_i,
  output logic      [WIDTH-1:0] filt_o
);
  localparam int CNT_W = $clog2(FILT_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_END = CNT_W'(FILT_CYC);

  if (FILT_CYC < 1 || WIDTH < 1) begin : g_chk
    $error("fbr_pin_filt: FILT_CYC and WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] last_ff;
  logic [CNT_W-1:0] cnt_ff;
  wire              same = (s2_ff == last_ff);
  wire              stable = same && (cnt_ff == CNT_END);

  // A change must persist for FILT_CYC + 2 samples before it is passed on
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_ff   <= RST_VAL;
      s2_ff   <= RST_VAL;
      last_ff <= RST_VAL;
      cnt_ff  <= '0;
      filt_o  <= RST_VAL;
    end else begin
      s1_ff   <= pins_i;
      s2_ff   <= s1_ff;
      last_ff <= s2_ff;
      cnt_ff  <= !same ? '0 : (stable ? cnt_ff : cnt_ff + 1'b1);
      if (stable) filt_o <= last_ff;
    end
  end

endmodule // fbr_pin_filt

// [fbr_flash_bus.sv]
// Bus operation and read-mode engine of a parallel burst flash
`timescale 1ns/10ps
module fbr_flash_bus #(
  parameter int RAND_ACCESS_NS = 100,
  parameter int PAGE_ACCESS_NS = 30
)(
  input  wire logic                       clk_i,
  input  wire logic                       nrst_i,
  input  wire fbr_pkg::fbr_ctl_t          ctl_pins_i,
  input  wire logic [fbr_pkg::ADDR_W-1:0] address_pins_i,
  input  wire logic [fbr_pkg::DATA_W-1:0] data_pins_i,
  output logic      [fbr_pkg::DATA_W-1:0] data_pins_o,
  output logic                            data_pins_oe_o,
  output logic                            ready_o,
  output logic                            ready_oe_o,
  input  wire fbr_pkg::fbr_cfg_t          cfg_i,
  input  wire logic                       cfg_load_i,
  input  wire logic                       pe_busy_i,
  input  wire logic                       mem_is_array_i,
  input  wire logic [fbr_pkg::DATA_W-1:0] mem_rdata_i,
  output logic      [fbr_pkg::ADDR_W-1:0] mem_addr_o,
  output logic                            cmd_wr_o,
  output logic      [fbr_pkg::ADDR_W-1:0] cmd_addr_o,
  output logic      [fbr_pkg::DATA_W-1:0] cmd_data_o,
  output logic                            standby_o,
  output logic                            powerdown_o,
  output logic                            low_power_o
);
  import fbr_pkg::*;

  localparam int RAND_RAW = (RAND_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAND_CYC = (RAND_RAW < 1) ? 1 : RAND_RAW;
  localparam int PAGE_RAW = (PAGE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_CYC = (PAGE_RAW < 1) ? 1 : PAGE_RAW;
  localparam int ACC_W    = $clog2(RAND_CYC + 1);
  localparam logic [ACC_W-1:0] RAND_LOAD = ACC_W'(RAND_CYC);
  localparam logic [ACC_W-1:0] PAGE_LOAD = ACC_W'(PAGE_CYC);

  if (PAGE_CYC > RAND_CYC) begin : g_chk
    $error("fbr_flash_bus: page access must not exceed random access");
  end

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [$bits(fbr_ctl_t)-1:0] ctl_raw;
  fbr_ctl_t                    ctl;
  logic [ADDR_W-1:0]           addr_s1_ff;
  logic [ADDR_W-1:0]           addr_s_ff;
  logic [DATA_W-1:0]           data_s1_ff;
  logic [DATA_W-1:0]           data_s_ff;

  fbr_pin_filt #(
    .WIDTH    ($bits(fbr_ctl_t)),
    .FILT_CYC (GLITCH_CYC),
    .RST_VAL  (CTL_IDLE)
  ) u_filt (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .pins_i (ctl_pins_i),
    .filt_o (ctl_raw)
  );
  assign ctl = fbr_ctl_t'(ctl_raw);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_s1_ff <= '0;
      addr_s_ff  <= '0;
      data_s1_ff <= '0;
      data_s_ff  <= '0;
    end else begin
      addr_s1_ff <= address_pins_i;
      addr_s_ff  <= addr_s1_ff;
      data_s1_ff <= data_pins_i;
      data_s_ff  <= data_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fbr_cfg_t          cfg_ff;
  fbr_bst_t          state_ff;
  logic              bclk_q_ff;
  logic              latch_q_ff;
  logic              wr_q_ff;
  logic [3:0]        ctl_q_ff;
  logic [ADDR_W-1:0] lat_addr_ff;
  logic [ADDR_W-1:0] base_ff;
  logic [3:0]        cnt_ff;
  logic [3:0]        lat_tgt_ff;
  logic [2:0]        beat_ff;
  logic [2:0]        mask_ff;
  logic              cont_ff;
  logic              misal_ff;
  logic              seq_ff;
  logic              waited_ff;
  logic              last_ff;
  logic [ACC_W-1:0]  acc_ff;
  logic [ACC_W-1:0]  idle_ff;
  logic [ADDR_W-3:0] page_tag_ff;
  logic              page_vld_ff;
  logic [ADDR_W-1:0] prev_addr_ff;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire rp        = ctl.reset_powerdown_n;
  wire ce        = rp && !ctl.ce_n;
  wire oe        = !ctl.oe_n;
  wire we        = !ctl.we_n;
  wire lat_low   = !ctl.latch_n;
  wire is_async  = cfg_ff.read_select_bit;
  wire clk_rise  = ctl.bus_clk && !bclk_q_ff;
  wire clk_fall  = !ctl.bus_clk && bclk_q_ff;
  wire act_edge  = cfg_ff.active_edge_bit ? clk_rise : clk_fall;
  wire latch_rise = ctl.latch_n && !latch_q_ff;

  // Writes assume the host keeps the output gate high
  wire wr_now  = ce && we && !oe;
  wire wr_fire = wr_q_ff && !wr_now && rp;
  wire [ADDR_W-1:0] wr_addr = lat_low ? addr_s_ff : lat_addr_ff;

  wire start_clk = act_edge && ce && lat_low && !we;
  wire start_lat = latch_rise && ce && !we;
  wire burst_start = !is_async && (state_ff == B_IDLE) && (start_clk || start_lat);
  wire [ADDR_W-1:0] start_addr = start_clk ? addr_s_ff : lat_addr_ff;
  wire start_cont = (cfg_ff.burst_length_field == BL_CONT) && mem_is_array_i;
  // Non-array data is served as a single synchronous read
  wire [2:0] start_mask = !mem_is_array_i ? MASK_1 :
                          (cfg_ff.burst_length_field == BL_8) ? MASK_8 : MASK_4;

  wire wait_edge = act_edge && (state_ff == B_DATA) && cont_ff && misal_ff && !waited_ff &&
                   (mem_addr_o[1:0] == PAGE_FIRST);
  wire advance   = act_edge && (((state_ff == B_LAT) && (cnt_ff == 4'h1)) ||
                   ((state_ff == B_DATA) && !wait_edge && !last_ff));
  wire early     = advance && cont_ff && misal_ff && !waited_ff && (mem_addr_o[1:0] == PAGE_LAST);
  wire [2:0] nxt_beat = beat_ff + 3'h1;
  wire [ADDR_W-1:0] nxt_burst_addr = cont_ff ? mem_addr_o + ADDR_W'(1) :
                                     fbr_burst_addr(base_ff, nxt_beat, mask_ff, seq_ff);
  wire burst_end = act_edge && (state_ff == B_DATA) && last_ff;
  wire burst_kill = !ce || is_async;

  wire rd_async  = is_async && ce && oe && !we;
  wire addr_chg  = lat_addr_ff != prev_addr_ff;
  wire page_hit  = page_vld_ff && (lat_addr_ff[ADDR_W-1:2] == page_tag_ff);
  wire activity  = addr_chg || (ctl_q_ff != {ctl.ce_n, ctl.oe_n, ctl.we_n, ctl.latch_n});
  wire sync_drive = (state_ff == B_DATA);
  // No drive until a newly presented address sits in the latch and its access time has run
  wire lat_pend  = lat_low && ce && !we && (addr_s_ff != lat_addr_ff);
  wire nxt_oe    = rp && ce && oe && !we &&
                   (is_async ? (acc_ff == '0 && !addr_chg && !lat_pend) : sync_drive);

  logic nxt_rdy_low;
  assign nxt_rdy_low = (!ce || state_ff == B_IDLE) ? 1'b0 :
                       act_edge ? (cfg_ff.ready_timing_bit ? early : wait_edge) : ready_oe_o;

  // ----------------------------------------------------------------
  // Configuration and address latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_ff      <= CFG_RESET;
      lat_addr_ff <= '0;
    end else begin
      if (!rp) cfg_ff <= CFG_RESET;
      else if (cfg_load_i) cfg_ff <= cfg_i;
      // Transparent while low, frozen by the rising edge
      if (lat_low && ce && !we) lat_addr_ff <= addr_s_ff;
    end
  end

  // ----------------------------------------------------------------
  // Edge history and writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bclk_q_ff  <= 1'b0;
      latch_q_ff <= 1'b1;
      wr_q_ff    <= 1'b0;
      ctl_q_ff   <= '1;
      cmd_wr_o   <= 1'b0;
      cmd_addr_o <= '0;
      cmd_data_o <= '0;
    end else begin
      bclk_q_ff  <= ctl.bus_clk;
      latch_q_ff <= ctl.latch_n;
      wr_q_ff    <= wr_now;
      ctl_q_ff   <= {ctl.ce_n, ctl.oe_n, ctl.we_n, ctl.latch_n};
      cmd_wr_o   <= wr_fire;
      if (wr_fire) begin
        cmd_addr_o <= wr_addr;
        cmd_data_o <= data_s_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Synchronous burst engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff   <= B_IDLE;
      base_ff    <= '0;
      cnt_ff     <= '0;
      lat_tgt_ff <= '0;
      beat_ff    <= '0;
      mask_ff    <= MASK_4;
      cont_ff    <= 1'b0;
      misal_ff   <= 1'b0;
      seq_ff     <= 1'b1;
      waited_ff  <= 1'b0;
      last_ff    <= 1'b0;
    end else if (burst_kill && state_ff != B_IDLE) begin
      state_ff <= B_IDLE;
    end else if (burst_start) begin
      state_ff   <= B_LAT;
      base_ff    <= start_addr;
      cnt_ff     <= fbr_lat_cycles(cfg_ff.first_access_latency);
      lat_tgt_ff <= fbr_lat_cycles(cfg_ff.first_access_latency);
      beat_ff    <= '0;
      mask_ff    <= start_mask;
      cont_ff    <= start_cont;
      misal_ff   <= start_addr[1:0] != PAGE_FIRST;
      seq_ff     <= cfg_ff.burst_order_bit;
      waited_ff  <= 1'b0;
      last_ff    <= 1'b0;
    end else if (burst_end) begin
      state_ff <= B_IDLE;
    end else if (wait_edge) begin
      waited_ff <= 1'b1;
    end else if (advance) begin
      state_ff <= B_DATA;
      beat_ff  <= nxt_beat;
      last_ff  <= !cont_ff && (beat_ff == mask_ff);
    end else if (act_edge && state_ff == B_LAT) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Asynchronous access timing, page buffer and low power
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_ff       <= RAND_LOAD;
      idle_ff      <= '0;
      page_tag_ff  <= '0;
      page_vld_ff  <= 1'b0;
      prev_addr_ff <= '0;
      low_power_o  <= 1'b0;
    end else begin
      prev_addr_ff <= lat_addr_ff;
      if (!is_async || wr_fire || !rp) begin
        page_vld_ff <= 1'b0;
        acc_ff      <= RAND_LOAD;
      end else if (addr_chg) begin
        acc_ff      <= page_hit ? PAGE_LOAD : RAND_LOAD;
        page_tag_ff <= lat_addr_ff[ADDR_W-1:2];
        page_vld_ff <= 1'b1;
      end else if (acc_ff != '0) begin
        acc_ff <= acc_ff - 1'b1;
      end
      idle_ff     <= activity ? '0 : ((idle_ff == RAND_LOAD) ? idle_ff : idle_ff + 1'b1);
      // Low power does not touch the output drive
      low_power_o <= is_async && rp && !activity && (idle_ff == RAND_LOAD);
    end
  end

  // ----------------------------------------------------------------
  // Pins and status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_addr_o     <= '0;
      data_pins_o    <= '0;
      data_pins_oe_o <= 1'b0;
      ready_o        <= 1'b0;
      ready_oe_o     <= 1'b0;
      standby_o      <= 1'b0;
      powerdown_o    <= 1'b1;
    end else begin
      if (is_async) mem_addr_o <= lat_addr_ff;
      else if (burst_start) mem_addr_o <= start_addr;
      else if (advance) mem_addr_o <= nxt_burst_addr;
      if (is_async || advance) data_pins_o <= mem_rdata_i;
      data_pins_oe_o <= nxt_oe;
      ready_o        <= 1'b0;
      ready_oe_o     <= nxt_rdy_low;
      standby_o      <= rp && ctl.ce_n && !pe_busy_i;
      powerdown_o    <= !rp;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [3:0] lat_edges_ff;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) lat_edges_ff <= '0;
    else if (burst_start) lat_edges_ff <= '0;
    else if (act_edge && state_ff == B_LAT) lat_edges_ff <= lat_edges_ff + 4'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_gate_float:   assert property (ctl.oe_n |=> !data_pins_oe_o)
    else $error("data driven with output gate high");
  a_pd_float:     assert property (!rp |=> !data_pins_oe_o && !ready_oe_o && powerdown_o)
    else $error("outputs not floated in power-down");
  a_stby_float:   assert property (rp && ctl.ce_n && !pe_busy_i |=> standby_o && !data_pins_oe_o)
    else $error("standby not entered with chip deselected");
  a_busy_stby:    assert property (pe_busy_i |=> !standby_o)
    else $error("standby entered while program or erase runs");
  a_reset_async:  assert property (!rp |=> cfg_ff.read_select_bit && state_ff == B_IDLE)
    else $error("reset did not select asynchronous read");
  a_wr_capture:   assert property (wr_fire |=> cmd_wr_o && cmd_data_o == $past(data_s_ff)
                                   && cmd_addr_o == $past(wr_addr))
    else $error("write capture mismatch");
  a_first_lat:    assert property (act_edge && state_ff == B_LAT && cnt_ff == 4'h1 && ce && !is_async
                                   |-> lat_edges_ff + 4'h1 == lat_tgt_ff ##1 state_ff == B_DATA)
    else $error("first data not at configured latency");
  a_burst_len:    assert property (burst_end && !burst_kill |=> state_ff == B_IDLE)
    else $error("fixed burst ran past its length");
  a_ready_cause:  assert property ($rose(ready_oe_o) |-> $past(cont_ff && misal_ff && !waited_ff))
    else $error("ready pulled low without misaligned continuous burst");
  a_lp_async:     assert property (low_power_o |-> $past(is_async))
    else $error("low power outside asynchronous mode");
  a_cs_release:   assert property (ctl.ce_n && state_ff != B_IDLE |=> state_ff == B_IDLE
                                   ##1 !data_pins_oe_o)
    else $error("burst not ended by chip deselect");

  c_write:     cover property (wr_fire);
  c_async_rd:  cover property (rd_async && acc_ff == '0);
  c_burst:     cover property (state_ff == B_LAT ##[1:40] state_ff == B_DATA);
  c_wait:      cover property (ready_oe_o && state_ff == B_DATA);

endmodule // fbr_flash_bus

// [fbr_host_model.sv]
// Host bus master model driving the flash control, address and data pins
`timescale 1ns/10ps
module fbr_host_model (
  input  wire logic                       clk_i,
  output fbr_pkg::fbr_ctl_t               ctl_o,
  output logic      [fbr_pkg::ADDR_W-1:0] addr_o,
  output logic      [fbr_pkg::DATA_W-1:0] data_o,
  output logic                            data_oe_o
);
  import fbr_pkg::*;
  initial begin
    ctl_o = CTL_IDLE;
    addr_o = '0;
    data_o = '0;
    data_oe_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Bus clock stands low between frames
  task automatic idle(input logic rp);
    ctl_o = '{rp, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    data_oe_o = 1'b0;
  endtask
  task automatic oe(input logic v);
    ctl_o.oe_n = v;
  endtask
  // A one-cycle strobe is shorter than the pin filter and must be dropped
  task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input int lo);
    addr_o = a;
    data_o = d;
    data_oe_o = 1'b1;
    ctl_o = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    tick(lo);
    ctl_o.we_n = 1'b1;
    tick(6);
    idle(1'b1);
    tick(6);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic lat);
    addr_o = a;
    ctl_o = '{ctl_o.reset_powerdown_n, 1'b0, lat, 1'b1, 1'b0, 1'b0};
    if (lat) begin
      tick(6);
      ctl_o.latch_n = 1'b1;
      // Address held until the filtered latch rise has frozen it
      tick(6);
      addr_o = ~a;
      ctl_o.oe_n = 1'b0;
    end
  endtask
  task automatic bclk();
    ctl_o.bus_clk = 1'b1;
    tick(8);
    ctl_o.bus_clk = 1'b0;
    tick(8);
  endtask
endmodule // fbr_host_model

// [fbr_flash_bus_tb.sv]
// Self-checking bench for the flash bus read-mode engine
`timescale 1ns/10ps
module fbr_flash_bus_tb;
  import fbr_pkg::*;
  logic              clk_i = 1'b0;
  logic              nrst_i = 1'b0;
  fbr_ctl_t          ctl;
  fbr_cfg_t          cfg, c;
  logic [ADDR_W-1:0] addr, mem_addr, cmd_addr, a, e;
  logic [DATA_W-1:0] h_data, d_in, d_out, cmd_data, d;
  logic [DATA_W-1:0] last_ff = '0;
  logic [2:0]        m;
  logic              h_oe, d_oe, r_oe, r_lvl, cfg_load, pe_busy, is_arr, cmd_wr, stby, pdn, lpw, seen;
  int                n_errors, checks_done, n_wr, cycles, n, len;

  function automatic logic [DATA_W-1:0] word_of(input logic [ADDR_W-1:0] x);
    return x[15:0] ^ {x[20:16], 11'h2A5};
  endfunction
  function automatic logic [ADDR_W-1:0] beat(input logic [ADDR_W-1:0] x, input int i,
                                             input logic [2:0] mk, input logic seq);
    logic [2:0] lo;
    lo = seq ? x[2:0] + 3'(i) : x[2:0] ^ 3'(i);
    return {x[ADDR_W-1:3], (x[2:0] & ~mk) | (lo & mk)};
  endfunction
  task automatic chk_val(input string what, input logic [ADDR_W-1:0] exp, input logic [ADDR_W-1:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_flag(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic load(input fbr_cfg_t v);
    cfg = v;
    cfg_load = 1'b1;
    @(negedge clk_i);
    cfg_load = 1'b0;
  endtask
  task automatic wait_oe();
    for (int t = 0; t < 30 && d_oe !== 1'b1; t++) @(negedge clk_i);
  endtask

  // ---------------------------------------------------------------
  // Clock, shared data wire, write counter and run limit
  // ---------------------------------------------------------------
  always #25 clk_i = ~clk_i;
  assign d_in = d_oe ? d_out : h_oe ? h_data : ~last_ff;
  always @(posedge clk_i) begin
    cycles++;
    if (d_oe | h_oe) last_ff <= d_in;
    if (cmd_wr === 1'b1) n_wr++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end

  fbr_host_model host_u (
    .clk_i     (clk_i),
    .ctl_o     (ctl),
    .addr_o    (addr),
    .data_o    (h_data),
    .data_oe_o (h_oe)
  );
  fbr_flash_bus dut_u (
    .clk_i          (clk_i),
    .nrst_i         (nrst_i),
    .ctl_pins_i     (ctl),
    .address_pins_i (addr),
    .data_pins_i    (d_in),
    .data_pins_o    (d_out),
    .data_pins_oe_o (d_oe),
    .ready_o        (r_lvl),
    .ready_oe_o     (r_oe),
    .cfg_i          (cfg),
    .cfg_load_i     (cfg_load),
    .pe_busy_i      (pe_busy),
    .mem_is_array_i (is_arr),
    .mem_rdata_i    (word_of(mem_addr)),
    .mem_addr_o     (mem_addr),
    .cmd_wr_o       (cmd_wr),
    .cmd_addr_o     (cmd_addr),
    .cmd_data_o     (cmd_data),
    .standby_o      (stby),
    .powerdown_o    (pdn),
    .low_power_o    (lpw)
  );

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    cfg = CFG_RESET;
    cfg_load = 1'b0;
    pe_busy = 1'b0;
    is_arr = 1'b1;
    void'($urandom(32'h9721));
    repeat (5) @(negedge clk_i);
    chk_flag("reset powerdown", 1'b1, pdn);
    nrst_i = 1'b1;
    host_u.idle(1'b1);
    host_u.tick(8);
    for (int i = 0; i < 4; i++) begin
      a = ADDR_W'($urandom);
      d = DATA_W'($urandom);
      n = n_wr;
      host_u.write(a, d, (i == 0) ? 1 : 6);
      chk_val("write pulses", ADDR_W'(n + ((i == 0) ? 0 : 1)), ADDR_W'(n_wr));
      if (i > 0) chk_val("cmd addr", a, cmd_addr);
      if (i > 0) chk_val("cmd data", ADDR_W'(d), ADDR_W'(cmd_data));
    end
    $display("TEST writes done");
    for (int i = 0; i < 4; i++) begin
      a = ADDR_W'($urandom);
      pe_busy = 1'($urandom);
      host_u.rd(a, i[0]);
      wait_oe();
      chk_flag("read drive", 1'b1, d_oe);
      chk_val("read addr", a, mem_addr);
      chk_val("read data", ADDR_W'(word_of(a)), ADDR_W'(d_out));
      host_u.tick(10);
      chk_flag("auto low power", 1'b1, lpw);
      chk_flag("drive in low power", 1'b1, d_oe);
      host_u.oe(1'b1);
      host_u.tick(6);
      chk_flag("gate float", 1'b0, d_oe);
      host_u.idle(1'b1);
      host_u.tick(6);
      chk_flag("standby", !pe_busy, stby);
    end
    pe_busy = 1'b1;
    host_u.rd(a, 1'b0);
    host_u.tick(6);
    host_u.idle(1'b1);
    host_u.tick(8);
    chk_flag("standby while busy", 1'b0, stby);
    pe_busy = 1'b0;
    host_u.tick(3);
    chk_flag("standby after busy", 1'b1, stby);
    $display("TEST async reads done");
    for (int i = 0; i < 7; i++) begin
      c = CFG_RESET;
      c.read_select_bit = 1'b0;
      c.first_access_latency = 3'(2 + $urandom_range(4));
      c.ready_timing_bit = 1'($urandom);
      c.burst_order_bit = (i == 6) | 1'($urandom);
      c.active_edge_bit = 1'($urandom);
      c.burst_length_field = (i == 6) ? BL_CONT : i[0] ? BL_8 : BL_4;
      load(c);
      is_arr = (i != 4) && (i != 5 || 1'($urandom));
      n = 2 + int'(c.first_access_latency);
      len = (i == 6 || !is_arr) ? 1 : i[0] ? 8 : 4;
      m = (len == 8) ? 3'h7 : 3'h3;
      a = ADDR_W'($urandom);
      if (i == 6) a[1:0] = 2'h1;
      host_u.rd(a, 1'b0);
      host_u.tick(8);
      seen = 1'b0;
      for (int k = 0; k <= n + len + 6; k++) begin
        host_u.bclk();
        seen |= r_oe;
        if (k >= n && k < n + len) begin
          e = ADDR_W'(word_of(beat(a, k - n, m, c.burst_order_bit)));
          chk_val("burst data", e, ADDR_W'(d_out));
          chk_flag("burst drive", 1'b1, d_oe);
        end
        if (k == n + len && i < 6) break;
      end
      if (i < 6) begin
        chk_flag("burst end", 1'b0, d_oe);
        chk_flag("ready idle", 1'b0, seen);
      end else begin
        chk_flag("wait state", 1'b1, seen);
        chk_flag("ready level", 1'b0, r_lvl);
      end
      host_u.idle(1'b1);
      host_u.tick(8);
      chk_flag("burst released", 1'b0, d_oe);
    end
    $display("TEST bursts done");
    host_u.idle(1'b0);
    host_u.rd(a, 1'b0);
    host_u.tick(8);
    // A load while powered down must be refused
    load(c);
    chk_flag("powerdown", 1'b1, pdn);
    chk_flag("powerdown float", 1'b0, d_oe);
    host_u.idle(1'b1);
    host_u.tick(8);
    host_u.rd(a, 1'b0);
    wait_oe();
    chk_flag("drive after powerdown", 1'b1, d_oe);
    chk_val("async after powerdown", ADDR_W'(word_of(a)), ADDR_W'(d_out));
    $display("TEST power down done");
    test_done();
  end
endmodule // fbr_flash_bus_tb
